// ===== rtl/eerd_pkg.sv
package eerd_pkg;

   // Array geometry: one byte per location, counter sized to the array
   localparam int unsigned ADDR_W = 14;
   localparam int unsigned MEM_DEPTH = 16384;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;

   // Device select byte layout
   localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
   localparam int unsigned SEL_TYPE_MSB = 7;
   localparam int unsigned SEL_TYPE_LSB = 4;
   localparam int unsigned SEL_CE_MSB = 3;
   localparam int unsigned SEL_CE_LSB = 1;
   localparam int unsigned SEL_DIR_BIT = 0;
   localparam logic DIR_READ = 1'b1;

   // Bit slot counting within a byte
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // Prefetch buffer depth
   localparam logic [1:0] BUF_DEPTH = 2'h2;

   // Reset values
   localparam logic [ADDR_W-1:0] ADDR_RESET = 14'h0000;
   localparam logic [7:0] SHIFT_RESET = 8'h00;

   // Synchronised bus line levels
   typedef struct packed {
      logic scl;
      logic sda;
   } eerd_line_type;

   // Bus events found from the synchronised lines
   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
   } eerd_event_type;

   // Protocol states, one-hot
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_RX_SEL = 8'h02,
      ST_RX_AHI = 8'h04,
      ST_RX_ALO = 8'h08,
      ST_ACK = 8'h10,
      ST_WAIT_RS = 8'h20,
      ST_TX = 8'h40,
      ST_TX_ACK = 8'h80
   } eerd_state_type;

endpackage

// ===== rtl/eerd_target.sv
`timescale 1ns/1ps
`default_nettype none

module eerd_target (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Two-wire bus, open drain on data
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Board straps
   input wire logic [2:0] chip_enable_i,
   input wire logic write_protect_input_i,
   // Array preload from the user side
   input wire logic load_en_i,
   input wire logic [eerd_pkg::ADDR_W-1:0] load_addr_i,
   input wire logic [7:0] load_data_i,
   // Status
   output logic [eerd_pkg::ADDR_W-1:0] cur_addr_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers and bus event detection

   eerd_pkg::eerd_line_type sync_a; // First stage, read only by sync_b
   eerd_pkg::eerd_line_type sync_b; // Second stage, safe to use
   eerd_pkg::eerd_line_type line_d; // Previous safe level
   logic [2:0] ce_a; // Strap first stage, read only by ce_b
   logic [2:0] ce_b; // Strap level, safe to compare
   eerd_pkg::eerd_event_type ev; // Decoded events

   // Two flops per line, then one more for edge finding
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_a <= '{scl: 1'b1, sda: 1'b1};
         sync_b <= '{scl: 1'b1, sda: 1'b1};
         line_d <= '{scl: 1'b1, sda: 1'b1};
         ce_a <= 3'h0;
         ce_b <= 3'h0;
      end else begin
         sync_a <= '{scl: scl_i, sda: sda_i};
         sync_b <= sync_a;
         line_d <= sync_b;
         // Straps sit still on a board, but they still come from outside
         ce_a <= chip_enable_i;
         ce_b <= ce_a;
      end
   end

   // Start and Stop are data edges while the clock stays high
   assign ev.start = sync_b.scl & line_d.scl & line_d.sda & ~sync_b.sda;
   assign ev.stop = sync_b.scl & line_d.scl & ~line_d.sda & sync_b.sda;
   assign ev.rise = sync_b.scl & ~line_d.scl;
   assign ev.fall = ~sync_b.scl & line_d.scl;

   ////////////////////////////////////////////////////////////////////////////
   // Memory array

   // Erased contents at power up; no reset, a real array has none
   logic [7:0] mem [eerd_pkg::MEM_DEPTH] = '{default: eerd_pkg::ERASED_BYTE};

   // User preload port; reads never look at write protect
   always_ff @(posedge ref_clk_i) begin
      if (load_en_i) begin
         mem[load_addr_i] <= load_data_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two-entry prefetch buffer between array and shifter

   logic [7:0] buf_mem [2]; // Buffer slots
   logic buf_wr_ptr; // Fill pointer
   logic buf_rd_ptr; // Drain pointer
   logic [1:0] buf_count; // Occupancy
   logic [eerd_pkg::ADDR_W-1:0] fetch_addr; // Next location to fetch
   logic buf_flush; // Restart prefetch at the counter
   logic buf_pop; // Shifter takes a byte
   logic fill_ready; // Buffer can accept
   logic fill_push; // Byte enters the buffer
   logic drain_valid; // Byte available to the shifter
   logic [7:0] drain_data; // Head byte
   localparam logic [eerd_pkg::ADDR_W-1:0] ADDR_STEP = 14'h0001; // One location

   assign fill_ready = buf_count != eerd_pkg::BUF_DEPTH;
   assign fill_push = fill_ready & ~buf_flush; // Fetch stalls while full
   assign drain_valid = buf_count != 2'h0;
   assign drain_data = buf_mem[buf_rd_ptr];

   // Fetch address walks ahead; natural wrap of the counter width
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fetch_addr <= eerd_pkg::ADDR_RESET;
         buf_wr_ptr <= 1'b0;
         buf_rd_ptr <= 1'b0;
         buf_count <= 2'h0;
      end else if (buf_flush) begin
         // Old prefetch is stale once the counter is chosen again
         fetch_addr <= cur_addr_o;
         buf_wr_ptr <= 1'b0;
         buf_rd_ptr <= 1'b0;
         buf_count <= 2'h0;
      end else begin
         if (fill_push) begin
            fetch_addr <= fetch_addr + ADDR_STEP;
            buf_wr_ptr <= ~buf_wr_ptr;
         end
         if (buf_pop && drain_valid) begin
            buf_rd_ptr <= ~buf_rd_ptr;
         end
         buf_count <= buf_count + {1'b0, fill_push} - {1'b0, buf_pop & drain_valid};
      end
   end

   // Slot storage carries no reset
   always_ff @(posedge ref_clk_i) begin
      if (fill_push) begin
         buf_mem[buf_wr_ptr] <= mem[fetch_addr];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Protocol engine

   eerd_pkg::eerd_state_type state; // Current state
   eerd_pkg::eerd_state_type ack_next; // State after the ack slot
   logic [2:0] bit_cnt; // Bit slot within the byte
   logic [7:0] shift; // Receive and transmit shifter
   logic byte_full; // Eight bits received
   logic [7:0] addr_hi; // High address byte held
   logic master_ack; // Acknowledge sampled in slot nine
   logic sel_match; // Select byte names this device
   logic sel_read; // Select byte asks for a read

   assign sel_match = (shift[eerd_pkg::SEL_TYPE_MSB:eerd_pkg::SEL_TYPE_LSB]
                       == eerd_pkg::DEV_TYPE_CODE)
                      && (shift[eerd_pkg::SEL_CE_MSB:eerd_pkg::SEL_CE_LSB] == ce_b);
   assign sel_read = shift[eerd_pkg::SEL_DIR_BIT] == eerd_pkg::DIR_READ;
   assign sda_o = 1'b0; // Open drain: only ever pulls low

   // Flush when a read select is acked, so data starts at the counter
   assign buf_flush = (state == eerd_pkg::ST_RX_SEL) && ev.fall && byte_full
                      && sel_match && sel_read;
   // Shifter takes a byte at each load of the transmit path
   assign buf_pop = ev.fall && ((state == eerd_pkg::ST_ACK && ack_next == eerd_pkg::ST_TX)
                    || (state == eerd_pkg::ST_TX_ACK && master_ack));

   // Main sequencer; write protect is deliberately not an input to it
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= eerd_pkg::ST_IDLE;
         ack_next <= eerd_pkg::ST_IDLE;
         bit_cnt <= eerd_pkg::BIT_FIRST;
         shift <= eerd_pkg::SHIFT_RESET;
         byte_full <= 1'b0;
         addr_hi <= eerd_pkg::SHIFT_RESET;
         master_ack <= 1'b0;
         sda_oe_o <= 1'b0;
         cur_addr_o <= eerd_pkg::ADDR_RESET;
      end else if (ev.stop) begin
         // Stop anywhere ends the transaction
         state <= eerd_pkg::ST_IDLE;
         sda_oe_o <= 1'b0;
      end else if (ev.start) begin
         // Start or repeated Start: listen for a select byte
         state <= eerd_pkg::ST_RX_SEL;
         bit_cnt <= eerd_pkg::BIT_FIRST;
         byte_full <= 1'b0;
         sda_oe_o <= 1'b0;
      end else begin
         case (state)
            eerd_pkg::ST_IDLE: begin
               sda_oe_o <= 1'b0; // Standby, bus released
            end
            eerd_pkg::ST_RX_SEL, eerd_pkg::ST_RX_AHI, eerd_pkg::ST_RX_ALO: begin
               if (ev.rise) begin
                  // Sample on the clock rise, MSB first
                  shift <= {shift[6:0], sync_b.sda};
                  bit_cnt <= bit_cnt + 3'h1;
                  byte_full <= bit_cnt == eerd_pkg::BIT_LAST;
               end else if (ev.fall && byte_full) begin
                  byte_full <= 1'b0;
                  bit_cnt <= eerd_pkg::BIT_FIRST;
                  if (state == eerd_pkg::ST_RX_SEL) begin
                     if (sel_match) begin
                        // Ack slot driven low for a matching select
                        sda_oe_o <= 1'b1;
                        state <= eerd_pkg::ST_ACK;
                        ack_next <= sel_read ? eerd_pkg::ST_TX : eerd_pkg::ST_RX_AHI;
                     end else begin
                        state <= eerd_pkg::ST_IDLE;
                     end
                  end else if (state == eerd_pkg::ST_RX_AHI) begin
                     // High address byte comes first
                     addr_hi <= shift;
                     sda_oe_o <= 1'b1;
                     state <= eerd_pkg::ST_ACK;
                     ack_next <= eerd_pkg::ST_RX_ALO;
                  end else begin
                     // Dummy write loads the counter, upper bits beyond array dropped
                     cur_addr_o <= {addr_hi[eerd_pkg::ADDR_W-9:0], shift};
                     sda_oe_o <= 1'b1;
                     state <= eerd_pkg::ST_ACK;
                     ack_next <= eerd_pkg::ST_WAIT_RS;
                  end
               end
            end
            eerd_pkg::ST_ACK: begin
               if (ev.fall) begin
                  if (ack_next == eerd_pkg::ST_TX) begin
                     // First read byte: take from the buffer, drive MSB
                     shift <= drain_data;
                     sda_oe_o <= ~drain_data[7];
                     cur_addr_o <= cur_addr_o + ADDR_STEP;
                  end else begin
                     sda_oe_o <= 1'b0;
                  end
                  bit_cnt <= eerd_pkg::BIT_FIRST;
                  state <= ack_next;
               end
            end
            eerd_pkg::ST_WAIT_RS: begin
               // Only a repeated Start or a Stop moves on; data bytes are not for this path
               sda_oe_o <= 1'b0;
            end
            eerd_pkg::ST_TX: begin
               if (ev.fall) begin
                  if (bit_cnt == eerd_pkg::BIT_LAST) begin
                     // Eighth bit done: let go so the master can answer
                     sda_oe_o <= 1'b0;
                     state <= eerd_pkg::ST_TX_ACK;
                  end else begin
                     shift <= {shift[6:0], 1'b0};
                     sda_oe_o <= ~shift[6];
                     bit_cnt <= bit_cnt + 3'h1;
                  end
               end
            end
            eerd_pkg::ST_TX_ACK: begin
               if (ev.rise) begin
                  master_ack <= ~sync_b.sda;
               end else if (ev.fall) begin
                  if (master_ack) begin
                     // Burst continues from the next location
                     shift <= drain_data;
                     sda_oe_o <= ~drain_data[7];
                     cur_addr_o <= cur_addr_o + ADDR_STEP;
                     bit_cnt <= eerd_pkg::BIT_FIRST;
                     state <= eerd_pkg::ST_TX;
                  end else begin
                     // No ack: stop sending, back to standby
                     sda_oe_o <= 1'b0;
                     state <= eerd_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               state <= eerd_pkg::ST_IDLE;
               sda_oe_o <= 1'b0;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// ===== tb/eerd_target_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module eerd_target_monitor (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Two-wire bus
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   // Straps and preload
   input wire logic [2:0] chip_enable_i,
   input wire logic write_protect_input_i,
   input wire logic load_en_i,
   input wire logic [eerd_pkg::ADDR_W-1:0] load_addr_i,
   input wire logic [7:0] load_data_i,
   // Status
   input wire logic [eerd_pkg::ADDR_W-1:0] cur_addr_o
);
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   // Bus conditions at the pins, seen before the target's synchronisers
   sequence s_start;
      scl_i && $fell(sda_i);
   endsequence
   sequence s_stop;
      scl_i && $rose(sda_i);
   endsequence
   property p_pull_value;
      sda_o == 1'b0;
   endproperty
   property p_drive_after_fall;
      $rose(sda_oe_o) |-> !scl_i;
   endproperty
   property p_release_after_fall;
      $fell(sda_oe_o) |-> !scl_i;
   endproperty
   // Slots are one bus period apart, so no second change soon after one
   property p_slot_stands;
      $changed(sda_oe_o) |=> $stable(sda_oe_o) [*8];
   endproperty
   property p_steady_high;
      scl_i [*4] |-> $stable(sda_oe_o);
   endproperty
   property p_quiet_after_start;
      s_start |=> !sda_oe_o [*8];
   endproperty
   property p_quiet_after_stop;
      s_stop |=> (!sda_oe_o && $stable(cur_addr_o)) [*8];
   endproperty
   property p_reset_state;
      $fell(rst_i) |-> (!sda_oe_o && cur_addr_o == eerd_pkg::ADDR_RESET);
   endproperty
   a_pull_value: assert property (p_pull_value) else $error("data pull value not low");
   a_drive_after_fall: assert property (p_drive_after_fall) else $error("drive began in high");
   a_release_after_fall: assert property (p_release_after_fall) else $error("early release");
   a_slot_stands: assert property (p_slot_stands) else $error("data slot too short");
   a_steady_high: assert property (p_steady_high) else $error("data moved in high");
   a_quiet_after_start: assert property (p_quiet_after_start) else $error("drive after start");
   a_quiet_after_stop: assert property (p_quiet_after_stop) else $error("busy after stop");
   a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
endmodule
bind eerd_target eerd_target_monitor u_mon (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl_i),
   .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .chip_enable_i(chip_enable_i),
   .write_protect_input_i(write_protect_input_i), .load_en_i(load_en_i),
   .load_addr_i(load_addr_i), .load_data_i(load_data_i), .cur_addr_o(cur_addr_o));
`default_nettype wire

// ===== tb/eerd_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module eerd_bus_master (
   // Two-wire bus, data pulled low only
   output logic scl_o,
   output logic sda_pull_o,
   input wire logic sda_i
);
   // Quarter of the 64 ns bus period
   localparam time Q = 16;
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   // One slot; data changes only while the clock is low
   task automatic bit_slot(input logic val, output logic got);
      sda_pull_o = ~val;
      #Q scl_o = 1'b1;
      #Q got = sda_i;
      #Q scl_o = 1'b0;
      #Q;
   endtask
   // Start, or repeated start from a low clock
   task automatic start();
      sda_pull_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q sda_pull_o = 1'b1;
      #Q scl_o = 1'b0;
      #Q;
   endtask
   task automatic stop();
      sda_pull_o = 1'b1;
      #Q scl_o = 1'b1;
      #Q sda_pull_o = 1'b0;
      #Q;
   endtask
   task automatic send(input logic [7:0] v, output logic ack);
      logic got;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(v[i], got);
      end
      bit_slot(1'b1, got);
      ack = ~got;
   endtask
   // Acks to continue a burst, leaves the last byte unacknowledged
   task automatic recv(output logic [7:0] v, input logic ack_it);
      logic got;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, v[i]);
      end
      bit_slot(~ack_it, got);
   endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wp = 1'b0;
   logic load_en = 1'b0;
   logic [13:0] load_addr = 14'h0000;
   logic [7:0] load_data = 8'h00;
   wire scl;
   wire sda_pull;
   wire sda_oe;
   wire sda_drv;
   wire [13:0] cur_addr;
   // Data line has a pull-up; either party may pull it low
   wire sda = (sda_oe ? sda_drv : 1'b1) & ~sda_pull;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [7:0] b;
   logic ack;
   logic [13:0] exp_ptr;
   logic [7:0] ref_mem [logic [13:0]];
   localparam logic [7:0] SEL_R = {eerd_pkg::DEV_TYPE_CODE, 3'h5, 1'b1};
   localparam logic [7:0] SEL_W = {eerd_pkg::DEV_TYPE_CODE, 3'h5, 1'b0};
   initial begin
      forever #2.5 clk = ~clk;
   end
   eerd_target u_dut (.ref_clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_drv),
      .sda_oe_o(sda_oe), .chip_enable_i(3'h5), .write_protect_input_i(wp),
      .load_en_i(load_en), .load_addr_i(load_addr), .load_data_i(load_data),
      .cur_addr_o(cur_addr));
   eerd_bus_master u_mst (.scl_o(scl), .sda_pull_o(sda_pull), .sda_i(sda));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic preload(input logic [13:0] a, input logic [7:0] d);
      @(negedge clk);
      load_en = 1'b1;
      load_addr = a;
      load_data = d;
      ref_mem[a] = d;
      @(negedge clk);
      load_en = 1'b0;
   endtask
   // Data phase; expected bytes follow a wrapping reference pointer
   task automatic read_run(input int n);
      for (int i = 0; i < n; i++) begin
         u_mst.recv(b, i < n - 1);
         chk({8'h00, b}, {8'h00, ref_mem.exists(exp_ptr) ? ref_mem[exp_ptr] : 8'hFF});
         exp_ptr = exp_ptr + 14'h0001;
      end
      u_mst.stop();
   endtask
   task automatic rand_read(input logic [15:0] a, input int n);
      @(negedge clk);
      u_mst.start();
      u_mst.send(SEL_W, ack);
      chk({15'h0000, ack}, 16'h0001);
      u_mst.send(a[15:8], ack);
      u_mst.send(a[7:0], ack);
      u_mst.start();
      u_mst.send(SEL_R, ack);
      chk({15'h0000, ack}, 16'h0001);
      exp_ptr = a[13:0];
      read_run(n);
   endtask
   task automatic cur_read(input int n);
      @(negedge clk);
      u_mst.start();
      u_mst.send(SEL_R, ack);
      chk({15'h0000, ack}, 16'h0001);
      read_run(n);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_current();
      chk({2'b00, cur_addr}, 16'h0000);
      preload(14'h0000, 8'h5A);
      preload(14'h1234, 8'hC3);
      preload(14'h3FFE, 8'h11);
      preload(14'h3FFF, 8'h22);
      preload(14'h0004, 8'h3C);
      exp_ptr = 14'h0000;
      cur_read(1);
      chk({2'b00, cur_addr}, {2'b00, exp_ptr});
      $display("current read done");
   endtask
   // Write protect high must not disturb a read; only 14 address bits kept
   task automatic t_random();
      @(negedge clk);
      wp = 1'b1;
      rand_read(16'hD234, 1);
      chk({2'b00, cur_addr}, {2'b00, exp_ptr});
      @(negedge clk);
      wp = 1'b0;
      $display("random read done");
   endtask
   task automatic t_burst();
      rand_read(16'h3FFE, 4);
      cur_read(1);
      $display("burst read done");
   endtask
   task automatic t_mismatch();
      @(negedge clk);
      u_mst.start();
      u_mst.send({eerd_pkg::DEV_TYPE_CODE, 3'h2, 1'b1}, ack);
      chk({15'h0000, ack}, 16'h0000);
      u_mst.recv(b, 1'b0);
      chk({8'h00, b}, 16'h00FF);
      u_mst.stop();
      $display("mismatch done");
   endtask
   // Stop in mid-byte while the high nibble leaves the line free
   task automatic t_abort();
      preload(14'h0003, 8'hF0);
      @(negedge clk);
      u_mst.start();
      u_mst.send(SEL_R, ack);
      chk({15'h0000, ack}, 16'h0001);
      for (int i = 0; i < 3; i++) begin
         u_mst.bit_slot(1'b1, ack);
      end
      u_mst.stop();
      chk({2'b00, cur_addr}, 16'h0004);
      // A target still sending would pull the low nibble onto the line
      u_mst.recv(b, 1'b0);
      chk({8'h00, b}, 16'h00FF);
      u_mst.stop();
      rand_read(16'h0004, 1);
      $display("abort done");
   endtask
   // No ack in slot nine: the target must fall silent without a Stop
   task automatic t_nack();
      preload(14'h0011, 8'h00);
      @(negedge clk);
      u_mst.start();
      u_mst.send(SEL_W, ack);
      u_mst.send(8'h00, ack);
      u_mst.send(8'h10, ack);
      u_mst.start();
      u_mst.send(SEL_R, ack);
      chk({15'h0000, ack}, 16'h0001);
      u_mst.recv(b, 1'b0);
      chk({8'h00, b}, 16'h00FF);
      // Zero byte next: a target still sending would show it here
      u_mst.recv(b, 1'b0);
      chk({8'h00, b}, 16'h00FF);
      u_mst.stop();
      $display("nack done");
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Cut a hang short well past the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
      t_current();
      t_random();
      t_burst();
      t_mismatch();
      t_abort();
      t_nack();
      end_of_test();
   end
endmodule
`default_nettype wire
